// ---- rtl/ascii_framer_regs.svh ----
// Purpose: Constants of the ASCII slave framer: characters, codes, limits.
// Assumes: Included by its bare name.
// Notes: Definitions only.
`ifndef ASCII_FRAMER_REGS_SVH
`define ASCII_FRAMER_REGS_SVH

`define CH_COLON 8'h3A
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define HEX_DIGIT0 8'h30
`define HEX_DIGIT9 8'h39
`define HEX_LETTER_A 8'h41
`define HEX_LETTER_F 8'h46
`define HEX_TEN 8'h0A

`define FN_RD_COILS 8'h01
`define FN_RD_INPUTS 8'h02
`define FN_RD_REGS 8'h03
`define FN_WR_COIL 8'h05
`define FN_WR_REG 8'h06
`define FN_WR_COILS 8'h0F
`define FN_WR_REGS 8'h10
`define FN_SLAVE_INFO 8'h11
`define FN_LINK_RW 8'h17

`define EXC_FLAG 8'h80
`define EXC_BAD_FUNC 8'h01
`define EXC_BAD_ADDR 8'h02
`define EXC_BAD_DATA 8'h03
`define EXC_FRAME 8'h07
`define EXC_NONE 8'h00

`define ADDR_BCAST 8'h00
`define ADDR_MAX 8'hFE
// 205 payload bytes
`define PAYLOAD_MAX 8'hCD
// 100 registers, 2000 contacts
`define REG_MAX 16'h0064
`define BIT_MAX 16'h07D0
`define FIXED_LEN 8'h04
`define MULTI_MIN_LEN 8'h05
`define LINK_MIN_LEN 8'h09
`define HDR_BYTES 8'h02
`define TRAILER_BYTES 8'h03
`define CNT_SAT 8'hFF

`define DEF_EIGHT_BITS 1'b0
`define DEF_TWO_STOP 1'b0
`define RESP_FIFO_DEPTH 2

`endif

// ---- rtl/ascii_framer_pkg.sv ----
// Purpose: Types and hex helpers shared by the framer modules.
// Assumes: ascii_framer_regs.svh supplies the character constants.
// Notes: Functions are pure.
`include "ascii_framer_regs.svh"
package ascii_framer_pkg;
  typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_NONE} parity_t;
  typedef enum logic [3:0] {ST_HUNT, ST_BODY, ST_LF, ST_EVAL, ST_WAIT,
    ST_COLON, ST_ADDR, ST_FUNC, ST_BCNT, ST_EXC, ST_DATA, ST_LRC, ST_CR,
    ST_LFOUT} frame_state_t;

  function automatic logic [7:0] nib_to_hex(input logic [3:0] nib);
    if (nib < 4'hA) begin
      return `HEX_DIGIT0 + {4'h0, nib};
    end
    return `HEX_LETTER_A + {4'h0, nib} - `HEX_TEN;
  endfunction

  // Bit 4 flags a character that is no upper-case hex digit
  function automatic logic [4:0] hex_to_nib(input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (c >= `HEX_DIGIT0 && c <= `HEX_DIGIT9) begin
      v = c - `HEX_DIGIT0;
      return {1'b0, v[3:0]};
    end
    if (c >= `HEX_LETTER_A && c <= `HEX_LETTER_F) begin
      v = c - `HEX_LETTER_A + `HEX_TEN;
      return {1'b0, v[3:0]};
    end
    return 5'h10;
  endfunction
endpackage

// ---- rtl/resp_fifo.sv ----
// Purpose: Small FIFO between the application and the reply builder.
// Assumes: Both sides on mclk.
// Notes: in_ready comes from a flip-flop.
`timescale 1ns/10ps
module resp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("resp_fifo DEPTH must be a power of two, at least 2");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready <= (cnt_d < (AW + 1)'(DEPTH));
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

// ---- rtl/hex_char_tx.sv ----
// Purpose: Turns reply bytes into line characters, two hex or one raw.
// Assumes: Character sink on mclk with valid/ready.
// Notes: One idle cycle between bytes; the line is far slower anyway.
`timescale 1ns/10ps
module hex_char_tx
  import ascii_framer_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_val,
  input wire logic byte_raw,
  output logic byte_ready,
  output logic char_valid_q,
  output logic [7:0] char_q,
  input wire logic char_ready
);
  logic lo_pend_q;
  logic [3:0] lo_q;

  assign byte_ready = !char_valid_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      char_valid_q <= 1'b0;
      char_q <= 8'h00;
      lo_pend_q <= 1'b0;
      lo_q <= 4'h0;
    end else if (!char_valid_q) begin
      if (byte_valid) begin
        char_valid_q <= 1'b1;
        lo_q <= byte_val[3:0];
        lo_pend_q <= !byte_raw;
        // High nibble leaves first
        char_q <= byte_raw ? byte_val : nib_to_hex(byte_val[7:4]);
      end
    end else if (char_ready) begin
      if (lo_pend_q) begin
        char_q <= nib_to_hex(lo_q);
        lo_pend_q <= 1'b0;
      end else begin
        char_valid_q <= 1'b0;
      end
    end
  end
endmodule

// ---- rtl/ascii_slave_framer.sv ----
// Purpose: Slave framer for colon-started hex-character serial frames.
// Assumes: Character UART runs on mclk and hands over checked characters.
// Notes: Half duplex; characters arriving while a reply is built are lost.
`timescale 1ns/10ps
module ascii_slave_framer
  import ascii_framer_pkg::*;
#(
  parameter int PAY_DEPTH = 206
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] station_id,
  input wire logic fmt_load,
  input wire logic fmt_eight_bits,
  input wire logic [1:0] fmt_parity,
  input wire logic fmt_two_stop,
  output logic line_eight_bits_q,
  output logic [1:0] line_parity_q,
  output logic line_two_stop_q,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_char_err,
  output logic tx_char_valid_q,
  output logic [7:0] tx_char_q,
  input wire logic tx_char_ready,
  output logic req_valid_q,
  output logic [7:0] req_func_q,
  output logic [15:0] req_start_q,
  output logic [15:0] req_count_q,
  output logic [7:0] req_len_q,
  input wire logic [7:0] pay_rd_idx,
  output logic [7:0] pay_rd_data_q,
  input wire logic resp_valid,
  input wire logic [7:0] resp_byte,
  input wire logic resp_last,
  output logic resp_ready,
  input wire logic resp_exc,
  input wire logic [7:0] resp_exc_code,
  output logic frame_drop_q
);
  initial begin
    if (PAY_DEPTH < 206 || PAY_DEPTH > 253) begin
      $error("PAY_DEPTH must hold 205 payload bytes plus checksum");
    end
  end

  frame_state_t state_q;
  logic [7:0] pay_mem [PAY_DEPTH];
  logic [7:0] nbytes_q, rsum_q, tsum_q, addr_q, func_q, exc_code_q;
  logic [15:0] start_q, count_q;
  logic [3:0] hi_q;
  logic half_q, cerr_q, is_exc_q;
  logic [7:0] rx_c, rx_b, pay_len, bcnt;
  logic [4:0] dec;
  logic rx_take, is_colon, is_cr;
  logic eval_silent;
  logic [7:0] eval_code;
  logic tx_byte_valid, tx_raw, tx_ready, tx_fire;
  logic [7:0] tx_byte;
  logic fifo_valid, fifo_ready;
  logic [8:0] fifo_data;

  function automatic logic fn_supported(input logic [7:0] f);
    case (f)
      `FN_RD_COILS, `FN_RD_INPUTS, `FN_RD_REGS: return 1'b1;
      `FN_WR_COIL, `FN_WR_REG, `FN_WR_COILS, `FN_WR_REGS: return 1'b1;
      `FN_SLAVE_INFO, `FN_LINK_RW: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic fn_has_bcnt(input logic [7:0] f);
    return f == `FN_RD_COILS || f == `FN_RD_INPUTS || f == `FN_RD_REGS;
  endfunction

  // in seven-bit mode the stray eighth bit is not part of the char
  assign rx_c = line_eight_bits_q ? rx_char : {1'b0, rx_char[6:0]};
  assign dec = hex_to_nib(rx_c);
  assign rx_b = {hi_q, dec[3:0]};
  assign is_colon = (rx_c == `CH_COLON);
  assign is_cr = (rx_c == `CH_CR);
  assign rx_take = rx_char_valid &&
    (state_q == ST_HUNT || state_q == ST_BODY || state_q == ST_LF);
  assign pay_len = nbytes_q - `TRAILER_BYTES;
  assign bcnt = (func_q == `FN_RD_REGS) ? 8'(count_q << 1) :
    8'((count_q + 16'h0007) >> 3);

  // Line format register; reset value is the default format
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      line_eight_bits_q <= `DEF_EIGHT_BITS;
      line_parity_q <= PAR_EVEN;
      line_two_stop_q <= `DEF_TWO_STOP;
    end else if (fmt_load) begin
      line_eight_bits_q <= fmt_eight_bits;
      line_parity_q <= fmt_parity;
      line_two_stop_q <= fmt_two_stop;
    end
  end

  // Character to byte assembly
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      nbytes_q <= 8'h00;
      half_q <= 1'b0;
      hi_q <= 4'h0;
      rsum_q <= 8'h00;
      cerr_q <= 1'b0;
      addr_q <= 8'h00;
      func_q <= 8'h00;
      start_q <= 16'h0000;
      count_q <= 16'h0000;
    end else if (rx_take) begin
      if (is_colon) begin
        // A colon always restarts, even mid-frame
        nbytes_q <= 8'h00;
        half_q <= 1'b0;
        rsum_q <= 8'h00;
        cerr_q <= rx_char_err;
      end else if (state_q == ST_BODY && !is_cr) begin
        if (dec[4] || rx_char_err) begin
          cerr_q <= 1'b1;
        end
        if (!half_q) begin
          hi_q <= dec[3:0];
          half_q <= 1'b1;
        end else begin
          half_q <= 1'b0;
          rsum_q <= rsum_q + rx_b;
          if (nbytes_q != `CNT_SAT) begin
            nbytes_q <= nbytes_q + 8'h01;
          end
          case (nbytes_q)
            8'h00: addr_q <= rx_b;
            8'h01: func_q <= rx_b;
            8'h02: start_q[15:8] <= rx_b;
            8'h03: start_q[7:0] <= rx_b;
            8'h04: count_q[15:8] <= rx_b;
            8'h05: count_q[7:0] <= rx_b;
            default: ;
          endcase
        end
      end else if (state_q == ST_BODY) begin
        // A dangling half byte before CR is a broken pair
        if (half_q || rx_char_err) begin
          cerr_q <= 1'b1;
        end
      end else if (rx_char_err) begin
        cerr_q <= 1'b1;
      end
    end
  end

  // Payload store, checksum byte included; overlong tails are not kept
  always_ff @(posedge mclk) begin
    if (rx_take && state_q == ST_BODY && !is_colon && !is_cr && half_q &&
        nbytes_q >= `HDR_BYTES &&
        nbytes_q < `HDR_BYTES + 8'(PAY_DEPTH)) begin
      pay_mem[8'(nbytes_q - `HDR_BYTES)] <= rx_b;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pay_rd_data_q <= 8'h00;
    end else if (pay_rd_idx < 8'(PAY_DEPTH)) begin
      pay_rd_data_q <= pay_mem[pay_rd_idx];
    end else begin
      pay_rd_data_q <= 8'h00;
    end
  end

  // Decision on a complete frame, first match wins
  always_comb begin
    eval_silent = 1'b0;
    eval_code = `EXC_NONE;
    if (cerr_q || nbytes_q < `HDR_BYTES) begin
      eval_silent = 1'b1;
    end else if (addr_q == `ADDR_BCAST) begin
      eval_silent = 1'b1;
    end else if (addr_q > `ADDR_MAX) begin
      eval_silent = 1'b1;
    end else if (addr_q != station_id) begin
      eval_silent = 1'b1;
    end else if (rsum_q != 8'h00 || nbytes_q < `TRAILER_BYTES) begin
      eval_code = `EXC_FRAME;
    end else if (!fn_supported(func_q)) begin
      eval_code = `EXC_BAD_FUNC;
    end else if (pay_len > `PAYLOAD_MAX) begin
      eval_code = `EXC_FRAME;
    end else begin
      case (func_q)
        `FN_RD_COILS, `FN_RD_INPUTS, `FN_RD_REGS, `FN_WR_COIL,
        `FN_WR_REG: begin
          if (pay_len != `FIXED_LEN) begin
            eval_code = `EXC_FRAME;
          end
        end
        `FN_WR_COILS, `FN_WR_REGS: begin
          if (pay_len < `MULTI_MIN_LEN) begin
            eval_code = `EXC_FRAME;
          end
        end
        `FN_SLAVE_INFO: begin
          if (pay_len != 8'h00) begin
            eval_code = `EXC_FRAME;
          end
        end
        default: begin
          if (pay_len < `LINK_MIN_LEN) begin
            eval_code = `EXC_FRAME;
          end
        end
      endcase
      if (eval_code == `EXC_NONE) begin
        case (func_q)
          `FN_RD_REGS, `FN_WR_REGS: begin
            if (count_q == 16'h0000 || count_q > `REG_MAX) begin
              eval_code = `EXC_BAD_DATA;
            end
          end
          `FN_RD_COILS, `FN_RD_INPUTS, `FN_WR_COILS: begin
            if (count_q == 16'h0000 || count_q > `BIT_MAX) begin
              eval_code = `EXC_BAD_DATA;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Frame sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_HUNT;
    end else begin
      case (state_q)
        ST_HUNT: begin
          if (rx_take && is_colon) begin
            state_q <= ST_BODY;
          end
        end
        ST_BODY: begin
          if (rx_take && is_cr) begin
            state_q <= ST_LF;
          end
        end
        ST_LF: begin
          if (rx_take) begin
            if (is_colon) begin
              state_q <= ST_BODY;
            end else if (rx_c == `CH_LF) begin
              state_q <= ST_EVAL;
            end else begin
              state_q <= ST_HUNT;
            end
          end
        end
        ST_EVAL: begin
          if (eval_silent) begin
            state_q <= ST_HUNT;
          end else if (eval_code != `EXC_NONE) begin
            state_q <= ST_COLON;
          end else begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (resp_exc || fifo_valid) begin
            state_q <= ST_COLON;
          end
        end
        ST_COLON: if (tx_fire) state_q <= ST_ADDR;
        ST_ADDR: if (tx_fire) state_q <= ST_FUNC;
        ST_FUNC: begin
          if (tx_fire) begin
            if (is_exc_q) begin
              state_q <= ST_EXC;
            end else if (fn_has_bcnt(func_q)) begin
              state_q <= ST_BCNT;
            end else begin
              state_q <= ST_DATA;
            end
          end
        end
        ST_BCNT: if (tx_fire) state_q <= ST_DATA;
        ST_EXC: if (tx_fire) state_q <= ST_LRC;
        ST_DATA: if (tx_fire && fifo_data[8]) state_q <= ST_LRC;
        ST_LRC: if (tx_fire) state_q <= ST_CR;
        ST_CR: if (tx_fire) state_q <= ST_LFOUT;
        ST_LFOUT: if (tx_fire) state_q <= ST_HUNT;
        default: state_q <= ST_HUNT;
      endcase
    end
  end

  // Request hand-off and reply bookkeeping
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_valid_q <= 1'b0;
      req_func_q <= 8'h00;
      req_start_q <= 16'h0000;
      req_count_q <= 16'h0000;
      req_len_q <= 8'h00;
      is_exc_q <= 1'b0;
      exc_code_q <= 8'h00;
      frame_drop_q <= 1'b0;
      tsum_q <= 8'h00;
    end else begin
      req_valid_q <= 1'b0;
      frame_drop_q <= 1'b0;
      if (state_q == ST_EVAL) begin
        frame_drop_q <= eval_silent;
        is_exc_q <= (eval_code != `EXC_NONE);
        exc_code_q <= eval_code;
        if (!eval_silent && eval_code == `EXC_NONE) begin
          req_valid_q <= 1'b1;
          req_func_q <= func_q;
          req_start_q <= start_q;
          req_count_q <= count_q;
          req_len_q <= pay_len;
        end
      end
      if (state_q == ST_WAIT && resp_exc) begin
        is_exc_q <= 1'b1;
        exc_code_q <= resp_exc_code;
      end
      if (state_q == ST_COLON) begin
        tsum_q <= 8'h00;
      end else if (tx_fire && !tx_raw && state_q != ST_LRC) begin
        tsum_q <= tsum_q + tx_byte;
      end
    end
  end

  // Byte feed to the character serializer
  always_comb begin
    tx_byte_valid = 1'b1;
    tx_byte = 8'h00;
    tx_raw = 1'b0;
    fifo_ready = 1'b0;
    case (state_q)
      ST_COLON: begin
        tx_byte = `CH_COLON;
        tx_raw = 1'b1;
      end
      ST_ADDR: tx_byte = addr_q;
      ST_FUNC: tx_byte = is_exc_q ? (func_q | `EXC_FLAG) : func_q;
      ST_BCNT: tx_byte = bcnt;
      ST_EXC: tx_byte = exc_code_q;
      ST_DATA: begin
        tx_byte_valid = fifo_valid;
        tx_byte = fifo_data[7:0];
        fifo_ready = tx_ready;
      end
      ST_LRC: tx_byte = ~tsum_q + 8'h01;
      ST_CR: begin
        tx_byte = `CH_CR;
        tx_raw = 1'b1;
      end
      ST_LFOUT: begin
        tx_byte = `CH_LF;
        tx_raw = 1'b1;
      end
      default: tx_byte_valid = 1'b0;
    endcase
  end
  assign tx_fire = tx_byte_valid && tx_ready;

  resp_fifo #(.WIDTH(9), .DEPTH(`RESP_FIFO_DEPTH)) u_resp_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(resp_valid),
    .in_data({resp_last, resp_byte}),
    .in_ready(resp_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_ready)
  );

  hex_char_tx u_hex_char_tx (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .byte_valid(tx_byte_valid),
    .byte_val(tx_byte),
    .byte_raw(tx_raw),
    .byte_ready(tx_ready),
    .char_valid_q(tx_char_valid_q),
    .char_q(tx_char_q),
    .char_ready(tx_char_ready)
  );
endmodule

// ---- testbench/ascii_slave_framer_properties.sv ----
// Purpose: Port-level checks of the slave framer.
// Assumes: Bound into the framer; all on mclk.
// Notes: rst_state_a lifts the reset disable.
`timescale 1ns/10ps
module ascii_slave_framer_properties
  import ascii_framer_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic fmt_load,
  input wire logic fmt_eight_bits,
  input wire logic [1:0] fmt_parity,
  input wire logic fmt_two_stop,
  input wire logic line_eight_bits_q,
  input wire logic [1:0] line_parity_q,
  input wire logic line_two_stop_q,
  input wire logic tx_char_valid_q,
  input wire logic [7:0] tx_char_q,
  input wire logic tx_char_ready,
  input wire logic req_valid_q,
  input wire logic [7:0] req_func_q,
  input wire logic [15:0] req_count_q,
  input wire logic [7:0] req_len_q,
  input wire logic frame_drop_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  rst_state_a: assert property (disable iff (1'b0)
    $fell(sys_rst) |-> !tx_char_valid_q && !req_valid_q &&
    !line_eight_bits_q && line_parity_q == 2'h0 && !line_two_stop_q)
    else $error("state after reset wrong");
  fmt_load_a: assert property (fmt_load |=>
    line_eight_bits_q == $past(fmt_eight_bits) &&
    line_parity_q == $past(fmt_parity) &&
    line_two_stop_q == $past(fmt_two_stop))
    else $error("line format not loaded");
  tx_hold_a: assert property (tx_char_valid_q && !tx_char_ready |=>
    tx_char_valid_q && $stable(tx_char_q))
    else $error("char changed before taken");
  tx_hex_a: assert property (tx_char_valid_q |-> tx_char_q inside
    {[8'h30:8'h39], [8'h41:8'h46], 8'h3A, 8'h0D, 8'h0A})
    else $error("bad character sent");
  cr_lf_a: assert property (tx_char_valid_q && tx_char_ready &&
    tx_char_q == 8'h0D |-> ##[1:3] tx_char_valid_q && tx_char_q == 8'h0A)
    else $error("no line feed after return");
  req_func_a: assert property (req_valid_q |-> req_func_q inside
    {8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h11, 8'h17})
    else $error("bad function passed on");
  req_len_a: assert property (req_valid_q |-> req_len_q <= 8'hCD)
    else $error("payload too long passed on");
  reg_cnt_a: assert property (req_valid_q && req_func_q == 8'h03 |->
    req_count_q != 16'h0000 && req_count_q <= 16'h0064)
    else $error("register count bad");
  drop_pulse_a: assert property (frame_drop_q |=> !frame_drop_q)
    else $error("drop flag too long");
  drop_quiet_a: assert property (frame_drop_q |-> (!tx_char_valid_q) [*4])
    else $error("reply after dropped frame");
endmodule
bind ascii_slave_framer ascii_slave_framer_properties i_props (.*);

// ---- testbench/ascii_master_model.sv ----
// Purpose: Master model: sends frames, decodes replies.
// Assumes: One character every second cycle.
// Notes: slow stalls every other cycle.
`timescale 1ns/10ps
module ascii_master_model (
  input wire logic mclk,
  output logic rx_char_valid,
  output logic [7:0] rx_char,
  output logic rx_char_err,
  input wire logic tx_char_valid_q,
  input wire logic [7:0] tx_char_q,
  output logic tx_char_ready
);
  logic slow = 1'b0, half = 1'b0;
  logic [3:0] hi_n = 4'h0;
  logic [7:0] rb[$];
  int done_cnt = 0;
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    rx_char_err = 1'b0;
    tx_char_ready = 1'b0;
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction
  function automatic logic [3:0] nb(input logic [7:0] c);
    return (c < 8'h41) ? c[3:0] : c[3:0] + 4'h9;
  endfunction
  task automatic put_char(input logic [7:0] c, input logic err);
    @(negedge mclk);
    rx_char_valid = 1'b1;
    rx_char = c;
    rx_char_err = err;
    @(negedge mclk);
    rx_char_valid = 1'b0;
    // Idle bus never shows the old character
    rx_char = ~c;
    rx_char_err = 1'b0;
  endtask
  task automatic send_frame(input logic [7:0] b[$], input logic [7:0] adj,
    input logic err);
    logic [7:0] s = 8'h00;
    put_char(8'h3A, 1'b0);
    foreach (b[i]) begin
      s = s + b[i];
      put_char(hx(b[i][7:4]), 1'b0);
      put_char(hx(b[i][3:0]), err);
    end
    s = adj - s;
    put_char(hx(s[7:4]), 1'b0);
    put_char(hx(s[3:0]), 1'b0);
    put_char(8'h0D, 1'b0);
    put_char(8'h0A, 1'b0);
  endtask
  always @(negedge mclk) begin
    tx_char_ready = !slow || !tx_char_ready;
  end
  always @(posedge mclk) begin
    if (tx_char_valid_q === 1'b1 && tx_char_ready === 1'b1) begin
      if (tx_char_q == 8'h3A) begin
        rb.delete();
        half = 1'b0;
      end else if (tx_char_q == 8'h0A) begin
        done_cnt++;
      end else if (tx_char_q != 8'h0D) begin
        if (half) begin
          rb.push_back({hi_n, nb(tx_char_q)});
        end
        hi_n = nb(tx_char_q);
        half = !half;
      end
    end
  end
endmodule

// ---- testbench/test_ascii_slave_framer.sv ----
// Purpose: Self-checking bench of the slave framer.
// Assumes: Master model on the line side.
// Notes: Inputs change on falling edges.
`timescale 1ns/10ps
module test_ascii_slave_framer;
  logic mclk = 1'b0, sys_rst = 1'b1, fmt_load = 1'b0, resp_exc = 1'b0;
  logic fmt_eight_bits = 1'b0, fmt_two_stop = 1'b0;
  logic resp_valid = 1'b0, resp_last = 1'b0;
  logic [1:0] fmt_parity = 2'h0;
  logic [7:0] station_id = 8'h01, resp_byte = 8'h00;
  logic [7:0] resp_exc_code = 8'h00, pay_rd_idx = 8'h00;
  logic line_eight_bits_q, line_two_stop_q, rx_char_valid, rx_char_err;
  logic tx_char_valid_q, tx_char_ready, req_valid_q, resp_ready;
  logic frame_drop_q;
  logic [1:0] line_parity_q;
  logic [7:0] rx_char, tx_char_q, req_func_q, req_len_q, pay_rd_data_q;
  logic [15:0] req_start_q, req_count_q;
  logic [15:0] fmt_w;
  int error_cnt = 0, tests_run = 0;
  int req_n = 0, drop_n = 0;
  assign fmt_w = {12'h000, line_eight_bits_q, line_parity_q, line_two_stop_q};
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    req_n <= req_n + int'(req_valid_q === 1'b1);
    drop_n <= drop_n + int'(frame_drop_q === 1'b1);
  end
  ascii_slave_framer i_dut (.mclk, .sys_rst, .station_id, .fmt_load,
    .fmt_eight_bits, .fmt_parity, .fmt_two_stop, .line_eight_bits_q,
    .line_parity_q, .line_two_stop_q, .rx_char_valid, .rx_char,
    .rx_char_err, .tx_char_valid_q, .tx_char_q, .tx_char_ready,
    .req_valid_q, .req_func_q, .req_start_q, .req_count_q, .req_len_q,
    .pay_rd_idx, .pay_rd_data_q, .resp_valid, .resp_byte, .resp_last,
    .resp_ready, .resp_exc, .resp_exc_code, .frame_drop_q);
  ascii_master_model i_master (.mclk, .rx_char_valid, .rx_char,
    .rx_char_err, .tx_char_valid_q, .tx_char_q, .tx_char_ready);
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded: a silent block must not hang the run
  task automatic wait_chg(input string nm, ref int cnt, input int c0);
    for (int k = 0; k < 4000 && cnt == c0; k++) @(negedge mclk);
    if (cnt == c0) begin
      check(nm, 16'h0000, 16'h0001);
      conclude();
    end
  endtask
  function automatic logic [15:0] rsum();
    logic [7:0] s = 8'h00;
    foreach (i_master.rb[i]) s = s + i_master.rb[i];
    return {8'h00, s};
  endfunction
  task automatic app_send(input logic [7:0] b[$], output logic full);
    full = 1'b0;
    foreach (b[i]) begin
      resp_valid = 1'b1;
      resp_byte = b[i];
      resp_last = (i == b.size() - 1);
      for (int k = 0; k < 400 && resp_ready !== 1'b1; k++) begin
        full = 1'b1;
        @(negedge mclk);
      end
      @(negedge mclk);
    end
    resp_valid = 1'b0;
  endtask
  task automatic t_read();
    logic full;
    int d0;
    d0 = i_master.done_cnt;
    i_master.slow = 1'b1;
    i_master.send_frame({8'h01, 8'h03, 8'h04, 8'h01, 8'h00, 8'h03}, 8'h00,
      1'b0);
    wait_chg("req", req_n, req_n);
    check("start", req_start_q, 16'h0401);
    check("count", req_count_q, 16'h0003);
    check("len", {8'h00, req_len_q}, 16'h0004);
    pay_rd_idx = 8'h03;
    repeat (2) @(negedge mclk);
    check("payload", {8'h00, pay_rd_data_q}, 16'h0003);
    app_send({8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03}, full);
    wait_chg("reply", i_master.done_cnt, d0);
    check("stall", {15'h0, full}, 16'h0001);
    check("size", i_master.rb.size(), 16'h000A);
    check("addr", {8'h00, i_master.rb[0]}, 16'h0001);
    check("bcnt", {8'h00, i_master.rb[2]}, 16'h0006);
    for (int i = 0; i < 6; i++) begin
      check("data", {8'h00, i_master.rb[3 + i]}, i[0] ? (i + 1) / 2 : 0);
    end
    check("sum", rsum(), 16'h0000);
    $display("t_read done");
  endtask
  task automatic t_funcs();
    logic [7:0] fn[9] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h0F, 8'h10,
      8'h11, 8'h17};
    int ln[9] = '{4, 4, 4, 4, 4, 6, 7, 0, 9};
    logic [7:0] b[$];
    logic full;
    int n0, d0;
    for (int f = 0; f < 9; f++) begin
      b = {8'h01, fn[f]};
      for (int j = 0; j < ln[f]; j++) begin
        b.push_back((j == 4 && fn[f] == 8'h10) ? 8'h02 : 8'(j >= 3));
      end
      n0 = req_n;
      d0 = i_master.done_cnt;
      i_master.send_frame(b, 8'h00, 1'b0);
      wait_chg("req", req_n, n0);
      check("func", {8'h00, req_func_q}, {8'h00, fn[f]});
      app_send({8'hAA}, full);
      wait_chg("reply", i_master.done_cnt, d0);
      check("echo", {8'h00, i_master.rb[1]}, {8'h00, fn[f]});
      check("body", {8'h00, i_master.rb[2]}, (fn[f] == 8'h03) ? 16'h0002 :
        (fn[f] < 8'h03) ? 16'h0001 : 16'h00AA);
      check("sum", rsum(), 16'h0000);
    end
    $display("t_funcs done");
  endtask
  task automatic t_exc();
    logic [7:0] ef[5] = '{8'h04, 8'h03, 8'h03, 8'h06, 8'h03};
    logic [7:0] ec[5] = '{8'h01, 8'h03, 8'h07, 8'h07, 8'h02};
    logic [7:0] b[$];
    int n0, d0;
    for (int e = 0; e < 5; e++) begin
      b = {8'h01, ef[e], 8'h00, 8'h00};
      if (e != 3) begin
        b.push_back(8'h00);
      end
      b.push_back(8'(e != 1));
      n0 = req_n;
      d0 = i_master.done_cnt;
      i_master.send_frame(b, 8'(e == 2), 1'b0);
      if (e == 4) begin
        wait_chg("req", req_n, n0);
        resp_exc_code = 8'h02;
        resp_exc = 1'b1;
        @(negedge mclk);
        resp_exc = 1'b0;
      end
      wait_chg("reply", i_master.done_cnt, d0);
      check("size", i_master.rb.size(), 16'h0004);
      check("efunc", {8'h00, i_master.rb[1]}, {8'h00, ef[e] | 8'h80});
      check("code", {8'h00, i_master.rb[2]}, {8'h00, ec[e]});
      check("sum", rsum(), 16'h0000);
    end
    $display("t_exc done");
  endtask
  task automatic t_silent();
    logic [7:0] sa[4] = '{8'h00, 8'h05, 8'hFF, 8'h01};
    int n0, m0, d0;
    for (int s = 0; s < 4; s++) begin
      n0 = req_n;
      m0 = drop_n;
      d0 = i_master.done_cnt;
      i_master.send_frame({sa[s], 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h00,
        s == 3);
      wait_chg("drop", drop_n, m0);
      repeat (40) @(negedge mclk);
      check("req", 16'(req_n - n0), 16'h0000);
      check("reply", 16'(i_master.done_cnt - d0), 16'h0000);
    end
    $display("t_silent done");
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    check("fmt", fmt_w, 16'h0000);
    fmt_eight_bits = 1'b1;
    fmt_parity = 2'h1;
    fmt_two_stop = 1'b1;
    fmt_load = 1'b1;
    @(negedge mclk);
    fmt_load = 1'b0;
    check("fmt", fmt_w, 16'h000B);
    t_read();
    t_funcs();
    t_exc();
    t_silent();
    conclude();
  end
endmodule
